// file: logic/bgp_pkg.sv
// Register map, reset values, bus carriers and states of the GPIO port.
package bgp_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Bus geometry.
  localparam int unsigned BGP_ADDR_W = 12;
  localparam int unsigned BGP_DATA_W = 32;
  localparam int unsigned BGP_STRB_W = 4;
  localparam int unsigned BGP_LANE_W = 8;
  localparam int unsigned BGP_PORT_W_DEF = 8;

  ////////////////////////////////////////////////////////////////////////////
  // Byte offsets of the registers, one aligned word each.
  localparam logic [11:0] BGP_OFS_DATA = 12'h000;
  localparam logic [11:0] BGP_OFS_DIR = 12'h004;
  localparam logic [11:0] BGP_OFS_ANALOG = 12'h008;
  localparam logic [11:0] BGP_OFS_SENSE = 12'h00C;
  localparam logic [11:0] BGP_OFS_SET = 12'h010;
  localparam logic [11:0] BGP_OFS_CLR = 12'h014;
  localparam logic [11:0] BGP_WORD_MASK = 12'hFFC;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values, cut to the port width where they are used.
  localparam logic [31:0] BGP_DIR_RST = 32'hFFFFFFFF;
  localparam logic [31:0] BGP_ANALOG_RST = 32'hFFFFFFFF;
  localparam logic [31:0] BGP_LATCH_RST = 32'h00000000;
  localparam logic [1:0] BGP_SENSE_RST = 2'h0;
  localparam logic [31:0] BGP_RDATA_ZERO = 32'h00000000;

  ////////////////////////////////////////////////////////////////////////////
  // Capacitive sensing: pin positions and their bits in the sense register.
  localparam int unsigned BGP_SENSE_W = 2;
  localparam int unsigned BGP_SENSE_PIN_12 = 4;
  localparam int unsigned BGP_SENSE_PIN_13 = 5;
  localparam int unsigned BGP_SENSE_BIT_12 = 0;
  localparam int unsigned BGP_SENSE_BIT_13 = 1;

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave states and register selection.
  typedef enum logic [0:0] {
    BGP_ST_IDLE = 1'b0,
    BGP_ST_ACCESS = 1'b1
  } bgp_apb_st_t;

  typedef enum logic [2:0] {
    BGP_SEL_DATA = 3'h0,
    BGP_SEL_DIR = 3'h1,
    BGP_SEL_ANALOG = 3'h2,
    BGP_SEL_SENSE = 3'h3,
    BGP_SEL_SET = 3'h4,
    BGP_SEL_CLR = 3'h5,
    BGP_SEL_NONE = 3'h7
  } bgp_sel_t;

  ////////////////////////////////////////////////////////////////////////////
  // APB request and answer carriers.
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [3:0] pstrb;
  } bgp_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } bgp_apb_rsp_t;

endpackage : bgp_pkg

// file: logic/bgp_sync.sv
// Two-stage synchroniser for the asynchronous pin levels.
`timescale 1ns/10ps

module bgp_sync #(
  parameter int unsigned WIDTH = 8
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic nrst,
  // Asynchronous levels in, synchronised levels out.
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  // Both stages live in one state word; only stage two is read outside.
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] held;
  } bgp_sync_st_t;

  bgp_sync_st_t s_r;
  bgp_sync_st_t s_nxt;

  // The first stage feeds the second stage and nothing else.
  always_comb begin
    s_nxt.meta = async_i;
    s_nxt.held = s_r.meta;
  end

  // Registers both stages; reset clears them to a constant.
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign sync_o = s_r.held;

endmodule : bgp_sync

// file: logic/bgp_port.sv
// Bidirectional general-purpose port with an APB register slave.
//
// Behaviour
// - Port of pins, each usable as input or output, one bit per pin.
// - Direction bit one makes the pin an input with its driver off.
// - Direction bit zero enables the driver of a pin not handed to sensing; it drives the latch bit.
// - Data reads return sampled pin levels; data writes update the latch.
// - Every data, set or clear write samples pins, changes target bits, stores the whole byte.
// - Direction bits keep control of drivers even on analog pins.
// - Analog-select one makes digital reads of that pin return zero.
// - Analog select never changes pin drive enables, but latch writes store zero into analog pins' latch bits they do not set.
// - Data bit reads one for a high pin, zero for a low pin.
// - Data bits map one-to-one onto port pins, each readable and writable.
// - On variants without the port, data reads return zero.
// - Pins four and five work as digital I/O or capacitive sense inputs.
`timescale 1ns/10ps

module bgp_port #(
  parameter int unsigned PORT_WIDTH = 8,
  parameter bit PORT_PRESENT = 1'b1
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic nrst,
  // APB slave.
  input wire bgp_pkg::bgp_apb_req_t apb_req,
  output bgp_pkg::bgp_apb_rsp_t apb_rsp,
  // Port pins, split into level in, level out and output enable.
  input wire logic [PORT_WIDTH-1:0] pin_i,
  output logic [PORT_WIDTH-1:0] pin_o,
  output logic [PORT_WIDTH-1:0] pin_oe,
  // Analog path enables towards the analog input multiplexer.
  output logic [PORT_WIDTH-1:0] analog_path_en,
  // Capacitive sensing channels on pins four and five.
  output logic sense_ch12_en,
  output logic sense_ch13_en,
  output logic cap_sense_channel_12,
  output logic cap_sense_channel_13
);

  import bgp_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Parameter checks.

  // The sense pins must exist and the port must fit one bus word.
  // Pins four and five carry the sense channels, so narrower ports fail.
  generate
    if (PORT_WIDTH < BGP_SENSE_PIN_13 + 1 || PORT_WIDTH > BGP_DATA_W) begin
      $error("bgp_port: PORT_WIDTH must lie between 6 and 32.");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // State of the block.

  // One bit per pin; every per-pin register and mask uses this type.
  typedef logic [PORT_WIDTH-1:0] bgp_bits_t;

  // The whole state of the block: bus phase, the three pin registers, the sense
  // select, the drive enables, the captured read answer and error flag and the sampled sense levels.
  typedef struct packed {
    bgp_apb_st_t st;
    bgp_bits_t latch;
    bgp_bits_t fourth_port_direction;
    bgp_bits_t fourth_port_analog_select;
    logic [BGP_SENSE_W-1:0] sense_sel;
    bgp_bits_t drive_en;
    logic [BGP_DATA_W-1:0] rdata;
    logic err;
    logic [BGP_SENSE_W-1:0] sense_lvl;
  } bgp_state_t;

  // Reset leaves every pin an analog input with its driver off, so nothing
  // is driven onto the board until software has set the port up.
  localparam bgp_state_t BGP_STATE_RST = '{
    st: BGP_ST_IDLE,
    latch: BGP_LATCH_RST[PORT_WIDTH-1:0],
    fourth_port_direction: BGP_DIR_RST[PORT_WIDTH-1:0],
    fourth_port_analog_select: BGP_ANALOG_RST[PORT_WIDTH-1:0],
    sense_sel: BGP_SENSE_RST,
    drive_en: '0,
    rdata: BGP_RDATA_ZERO,
    err: 1'b0,
    sense_lvl: '0
  };

  bgp_state_t s_r;
  bgp_state_t s_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // Helper functions.

  // Maps a word address onto the register it selects.
  // The two low address bits are ignored; unmapped words give no register.
  function automatic bgp_sel_t bgp_decode(input logic [11:0] addr);
    logic [11:0] word;
    word = addr & BGP_WORD_MASK;
    case (word)
      BGP_OFS_DATA: bgp_decode = BGP_SEL_DATA;
      BGP_OFS_DIR: bgp_decode = BGP_SEL_DIR;
      BGP_OFS_ANALOG: bgp_decode = BGP_SEL_ANALOG;
      BGP_OFS_SENSE: bgp_decode = BGP_SEL_SENSE;
      BGP_OFS_SET: bgp_decode = BGP_SEL_SET;
      BGP_OFS_CLR: bgp_decode = BGP_SEL_CLR;
      default: bgp_decode = BGP_SEL_NONE;
    endcase
  endfunction : bgp_decode

  // Widens a port-wide value to a bus word with zeros above.
  // Read data above the port width is therefore always zero.
  function automatic logic [31:0] bgp_zext(input bgp_bits_t v);
    logic [31:0] w;
    w = BGP_RDATA_ZERO;
    w[PORT_WIDTH-1:0] = v;
    return w;
  endfunction : bgp_zext

  // Expands the byte strobes into one enable per port bit.
  // Each strobe covers one byte lane of the port, lowest lane first.
  function automatic bgp_bits_t bgp_lane_mask(input logic [3:0] strb);
    bgp_bits_t m;
    m = '0;
    for (int i = 0; i < PORT_WIDTH; i++) begin
      m[i] = strb[i / BGP_LANE_W];
    end
    return m;
  endfunction : bgp_lane_mask

  // Takes new bits where the mask is set and keeps the base elsewhere.
  // Used for the data, direction and analog-select writes.
  function automatic bgp_bits_t bgp_merge(input bgp_bits_t base,
                                          input bgp_bits_t nv,
                                          input bgp_bits_t mask);
    return (base & ~mask) | (nv & mask);
  endfunction : bgp_merge

  // Places the two sense select bits on their pin positions.
  // The result masks the drivers of the pins handed to sensing.
  function automatic bgp_bits_t bgp_sense_pins(
      input logic [BGP_SENSE_W-1:0] sel);
    bgp_bits_t p;
    p = '0;
    p[BGP_SENSE_PIN_12] = sel[BGP_SENSE_BIT_12];
    p[BGP_SENSE_PIN_13] = sel[BGP_SENSE_BIT_13];
    return p;
  endfunction : bgp_sense_pins

  ////////////////////////////////////////////////////////////////////////////
  // Pin input synchronisation.

  bgp_bits_t pin_sync;

  // The pins come from the board, so they pass two flip-flops first.
  // Reads and read-modify-write merges therefore see a level that is two
  // clock edges old; a pin that moves just before a write is not seen.
  bgp_sync #(
    .WIDTH(PORT_WIDTH)
  ) u_pin_sync (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .async_i(pin_i),
    .sync_o(pin_sync)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Digital read path and bus qualifiers.

  bgp_bits_t dig_read;
  bgp_bits_t wr_mask;
  bgp_sel_t sel;
  logic setup_phase;
  logic access_done;

  // Analog pins read as zero; the rest show the sampled pin level.
  // Writes merge into this same value, so an analog pin that also drives
  // as an output stores zero into its latch bit on a later latch write unless that write sets the bit.
  assign dig_read = pin_sync & ~s_r.fourth_port_analog_select;

  // Only the byte lanes that the master strobes are targeted.
  // Unstrobed data lanes still take the pin level, as the port always
  // rewrites the whole latch.
  assign wr_mask = bgp_lane_mask(apb_req.pstrb);

  // Register selected by the address on the bus.
  // The address is held through the access phase, so it is decoded live.
  assign sel = bgp_decode(apb_req.paddr);

  // A setup cycle opens a transfer; the access ends in one cycle.
  // The slave never stretches an access, so pready is the access itself.
  assign setup_phase = apb_req.psel && !apb_req.penable;
  assign access_done = (s_r.st == BGP_ST_ACCESS) && apb_req.psel &&
                       apb_req.penable;

  ////////////////////////////////////////////////////////////////////////////
  // Next state.

  // Runs the bus slave, the register writes and the pin drive enables.
  // Read data is captured in the setup cycle and writes commit at the
  // edge that ends the access, when the master sees pready high.
  always_comb begin
    s_nxt = s_r;
    case (s_r.st)
      BGP_ST_IDLE: begin
        if (setup_phase) begin
          s_nxt.st = BGP_ST_ACCESS;
          s_nxt.err = (sel == BGP_SEL_NONE);
          s_nxt.rdata = BGP_RDATA_ZERO;
          if (PORT_PRESENT) begin
            case (sel)
              BGP_SEL_DATA: begin
                s_nxt.rdata = bgp_zext(dig_read);
              end
              BGP_SEL_DIR: begin
                s_nxt.rdata = bgp_zext(s_r.fourth_port_direction);
              end
              BGP_SEL_ANALOG: begin
                s_nxt.rdata = bgp_zext(s_r.fourth_port_analog_select);
              end
              BGP_SEL_SENSE: begin
                s_nxt.rdata[BGP_SENSE_W-1:0] = s_r.sense_sel;
              end
              BGP_SEL_SET, BGP_SEL_CLR: begin
                s_nxt.rdata = bgp_zext(s_r.latch);
              end
              default: begin
                s_nxt.rdata = BGP_RDATA_ZERO;
              end
            endcase
          end
        end
      end
      BGP_ST_ACCESS: begin
        if (access_done) begin
          s_nxt.st = BGP_ST_IDLE;
          if (apb_req.pwrite && !s_r.err && PORT_PRESENT) begin
            // Data, set and clear writes sample the pins and store the whole merged word.
            // Set and clear are the same merge with an or or an and-not.
            case (sel)
              BGP_SEL_DATA: begin
                s_nxt.latch = bgp_merge(dig_read,
                                        apb_req.pwdata[PORT_WIDTH-1:0],
                                        wr_mask);
              end
              BGP_SEL_SET: begin
                s_nxt.latch = dig_read |
                              (apb_req.pwdata[PORT_WIDTH-1:0] &
                               wr_mask);
              end
              BGP_SEL_CLR: begin
                s_nxt.latch = dig_read &
                              ~(apb_req.pwdata[PORT_WIDTH-1:0] &
                                wr_mask);
              end
              BGP_SEL_DIR: begin
                s_nxt.fourth_port_direction = bgp_merge(
                    s_r.fourth_port_direction,
                    apb_req.pwdata[PORT_WIDTH-1:0], wr_mask);
              end
              BGP_SEL_ANALOG: begin
                s_nxt.fourth_port_analog_select = bgp_merge(
                    s_r.fourth_port_analog_select,
                    apb_req.pwdata[PORT_WIDTH-1:0], wr_mask);
              end
              BGP_SEL_SENSE: begin
                if (apb_req.pstrb[0]) begin
                  s_nxt.sense_sel = apb_req.pwdata[BGP_SENSE_W-1:0];
                end
              end
              default: begin
                s_nxt.sense_sel = s_r.sense_sel;
              end
            endcase
          end
        end else if (!apb_req.psel) begin
          // A master that drops select mid-transfer must not wedge the slave.
          s_nxt.st = BGP_ST_IDLE;
        end
      end
      default: begin
        // An illegal state code falls back to idle on the next edge.
        s_nxt.st = BGP_ST_IDLE;
      end
    endcase

    // Drivers follow direction and sense select; analog select plays no part here.
    // Pins handed to sensing are released whatever their direction bit.
    s_nxt.drive_en = ~s_nxt.fourth_port_direction &
                     ~bgp_sense_pins(s_nxt.sense_sel);
    if (!PORT_PRESENT) begin
      s_nxt.drive_en = '0;
    end

    // Sense channels pass the pin level only while selected.
    // They are registered so the sensing unit sees a clean level.
    s_nxt.sense_lvl[BGP_SENSE_BIT_12] = s_r.sense_sel[BGP_SENSE_BIT_12] &&
                                        pin_sync[BGP_SENSE_PIN_12];
    s_nxt.sense_lvl[BGP_SENSE_BIT_13] = s_r.sense_sel[BGP_SENSE_BIT_13] &&
                                        pin_sync[BGP_SENSE_PIN_13];
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register.

  // Registers the whole state word; reset loads the constant reset word.
  // The reset is synchronous, like every other register of the block.
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      s_r <= BGP_STATE_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus answer.

  // The slave answers in the first access cycle with no wait states.
  // Read data comes from a register, so it stands for the whole access.
  assign apb_rsp.pready = access_done;
  assign apb_rsp.prdata = s_r.rdata;
  assign apb_rsp.pslverr = access_done && s_r.err;

  ////////////////////////////////////////////////////////////////////////////
  // Pin side.

  // Every pin bit drives from its own latch bit whenever enabled.
  // The latch keeps its value while the driver is off only until a latch write
  // stores the sampled pin level there; a later change of direction drives that.
  assign pin_o = PORT_PRESENT ? s_r.latch : '0;
  assign pin_oe = s_r.drive_en;

  // Analog path opens for every pin with analog select set, on variants with the port; without it, it stays shut.
  // Direction is not consulted: an analog pin may still be driven.
  assign analog_path_en = PORT_PRESENT ? s_r.fourth_port_analog_select :
                                         '0;

  // Sense enables and sampled sense levels for the sensing unit.
  assign sense_ch12_en = s_r.sense_sel[BGP_SENSE_BIT_12];
  assign sense_ch13_en = s_r.sense_sel[BGP_SENSE_BIT_13];
  assign cap_sense_channel_12 = s_r.sense_lvl[BGP_SENSE_BIT_12];
  assign cap_sense_channel_13 = s_r.sense_lvl[BGP_SENSE_BIT_13];

endmodule : bgp_port

// file: bench/bgp_port_asserts.sv
// Concurrent checks on the port's bus answers and pin outputs.
`timescale 1ns/10ps
module bgp_port_asserts
  import bgp_pkg::*;
#(
  parameter int unsigned PORT_WIDTH = 8,
  parameter bit PORT_PRESENT = 1'b1
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic nrst,
  // Register bus.
  input wire bgp_pkg::bgp_apb_req_t apb_req,
  input wire bgp_pkg::bgp_apb_rsp_t apb_rsp,
  // Pin side.
  input wire logic [PORT_WIDTH-1:0] pin_o,
  input wire logic [PORT_WIDTH-1:0] pin_oe,
  input wire logic [PORT_WIDTH-1:0] analog_path_en,
  input wire logic sense_ch12_en,
  input wire logic sense_ch13_en
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////////////////////////////////////////
  // Word address and committed transfer, decoded once for all checks.
  logic [11:0] word;
  logic commit;
  logic latch_wr;
  assign word = apb_req.paddr & BGP_WORD_MASK;
  assign commit = apb_req.psel & apb_req.penable & apb_rsp.pready;
  assign latch_wr = commit & apb_req.pwrite & (word == BGP_OFS_DATA
    || word == BGP_OFS_SET || word == BGP_OFS_CLR);
  // A committed write to one register word.
  sequence s_wr(logic [11:0] a);
    commit && apb_req.pwrite && word == a;
  endsequence
  // A setup cycle followed by its access cycle.
  sequence s_setup_access;
    apb_req.psel && !apb_req.penable ##1 apb_req.psel && apb_req.penable;
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  // Every access phase is answered in its first cycle.
  AST_ZERO_WAIT: assert property (s_setup_access |-> apb_rsp.pready)
    else $error("access not answered at once");
  AST_LATCH_WR: assert property (s_wr(BGP_OFS_DATA) ##0 apb_req.pstrb[0]
    |=> pin_o == (PORT_PRESENT ? $past(apb_req.pwdata[PORT_WIDTH-1:0])
    : {PORT_WIDTH{1'b0}}))
    else $error("latch write not on pins next cycle");
  AST_LATCH_HOLD: assert property (!latch_wr |=> $stable(pin_o))
    else $error("latch changed without a write");
  AST_DIR_OE: assert property (s_wr(BGP_OFS_DIR) ##0 apb_req.pstrb[0]
    |=> pin_oe[3:0] == (PORT_PRESENT ? ~$past(apb_req.pwdata[3:0]) : 4'h0))
    else $error("driver enable does not follow direction");
  AST_ANA_KEEP: assert property (s_wr(BGP_OFS_ANALOG)
    |=> $stable(pin_oe) && $stable(pin_o))
    else $error("analog select changed the output");
  AST_ANA_READ: assert property (commit && !apb_req.pwrite
    && word == BGP_OFS_DATA |-> (apb_rsp.prdata[PORT_WIDTH-1:0]
    & analog_path_en) == '0)
    else $error("analog pin read as one");
  AST_UPPER_ZERO: assert property (apb_rsp.pready
    |-> apb_rsp.prdata[31:PORT_WIDTH] == '0)
    else $error("read data above port width");
  AST_ERR: assert property (apb_rsp.pready
    |-> apb_rsp.pslverr == (word > BGP_OFS_CLR))
    else $error("error response wrong for address");
  AST_SENSE_OFF: assert property (sense_ch12_en
    |-> !pin_oe[BGP_SENSE_PIN_12])
    else $error("sense pin four still driven");
  AST_SENSE_OFF13: assert property (sense_ch13_en
    |-> !pin_oe[BGP_SENSE_PIN_13])
    else $error("sense pin five still driven");
endmodule : bgp_port_asserts

bind bgp_port bgp_port_asserts #(.PORT_WIDTH(PORT_WIDTH),
  .PORT_PRESENT(PORT_PRESENT)) i_bgp_port_asserts (.ref_clk(ref_clk),
  .nrst(nrst), .apb_req(apb_req), .apb_rsp(apb_rsp), .pin_o(pin_o),
  .pin_oe(pin_oe), .analog_path_en(analog_path_en),
  .sense_ch12_en(sense_ch12_en), .sense_ch13_en(sense_ch13_en));

// file: bench/bgp_board_model.sv
// Board model: resolves each port pin from the driver and the board level.
`timescale 1ns/10ps
module bgp_board_model #(
  parameter int unsigned WIDTH = 8
) (
  // Driver side of the port.
  input wire logic [WIDTH-1:0] pin_o,
  input wire logic [WIDTH-1:0] pin_oe,
  // Level the board applies where the port lets go.
  input wire logic [WIDTH-1:0] ext_lvl,
  // Resolved pin levels.
  output logic [WIDTH-1:0] pin_i
);
  // Driven pins show the latch, released pins follow the board.
  assign pin_i = (pin_oe & pin_o) | (~pin_oe & ext_lvl);
endmodule : bgp_board_model

// file: bench/bidir_io_port_eight_bit_bench.sv
// Self-checking bench for the port, with a register model in logic vectors.
`timescale 1ns/10ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin failures++; \
  $display("unexpected t=%0t got %h exp %h", $time, a, b); end end
module bidir_io_port_eight_bit_bench;
  import bgp_pkg::*;
  logic ref_clk;
  logic nrst;
  bgp_apb_req_t req;
  bgp_apb_rsp_t rsp;
  bgp_apb_rsp_t rsp_abs;
  logic [7:0] pin_i, pin_o, pin_oe, ana, ext, v;
  logic ch12, ch13, cs12, cs13, rerr;
  logic [31:0] rdat;
  logic [7:0] m_lat, m_dir, m_ans;
  logic [1:0] m_sen;
  logic [11:0] a;
  int failures = 0;
  int n_tests = 0;
  int cyc = 0;
  bgp_port #(.PORT_WIDTH(8), .PORT_PRESENT(1'b1)) i_bgp_port (
    .ref_clk(ref_clk), .nrst(nrst), .apb_req(req), .apb_rsp(rsp),
    .pin_i(pin_i), .pin_o(pin_o), .pin_oe(pin_oe), .analog_path_en(ana),
    .sense_ch12_en(ch12), .sense_ch13_en(ch13),
    .cap_sense_channel_12(cs12), .cap_sense_channel_13(cs13));
  bgp_board_model #(.WIDTH(8)) i_bgp_board_model (.pin_o(pin_o),
    .pin_oe(pin_oe), .ext_lvl(ext), .pin_i(pin_i));
  // Variant without the port: shares the bus and must answer with zeros.
  bgp_port #(.PORT_WIDTH(8), .PORT_PRESENT(1'b0)) i_bgp_port_absent (
    .ref_clk(ref_clk), .nrst(nrst), .apb_req(req), .apb_rsp(rsp_abs),
    .pin_i(ext), .pin_o(), .pin_oe(), .analog_path_en(),
    .sense_ch12_en(), .sense_ch13_en(),
    .cap_sense_channel_12(), .cap_sense_channel_13());
  // Free-running clock.
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // Cuts a hung run short.
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      conclude();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Model: driver enables, pin levels and the digital read value.
  function automatic logic [7:0] m_oe();
    return ~m_dir & ~{2'h0, m_sen, 4'h0};
  endfunction : m_oe
  function automatic logic [7:0] m_pins();
    return (m_oe() & m_lat) | (~m_oe() & ext);
  endfunction : m_pins
  // Lets pin changes pass the synchroniser; ends off the rising edge.
  task automatic settle();
    repeat (4) @(negedge ref_clk);
  endtask : settle
  // One APB transfer. The request stands until a rising edge sees pready
  // high; the answer is taken and the bus released at that same edge.
  task automatic xfer(input logic w, input logic [11:0] ad,
      input logic [31:0] d, input logic [3:0] s);
    @(posedge ref_clk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: ad, pwdata: d,
      pstrb: s};
    @(posedge ref_clk);
    req.penable <= 1'b1;
    do begin
      @(posedge ref_clk);
    end while (rsp.pready !== 1'b1);
    rdat = rsp.prdata;
    rerr = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask : xfer
  // Register write, mirrored into the model as read-modify-write.
  task automatic wr(input logic [11:0] ad, input logic [7:0] d,
      input logic [3:0] s);
    logic [7:0] pr, sd;
    settle();
    pr = m_pins() & ~m_ans;
    sd = s[0] ? d : 8'h00;
    xfer(1'b1, ad, {24'h0, d}, s);
    case (ad)
      BGP_OFS_DATA: m_lat = s[0] ? d : pr;
      BGP_OFS_SET: m_lat = pr | sd;
      BGP_OFS_CLR: m_lat = pr & ~sd;
      BGP_OFS_DIR: m_dir = s[0] ? d : m_dir;
      BGP_OFS_ANALOG: m_ans = s[0] ? d : m_ans;
      BGP_OFS_SENSE: m_sen = s[0] ? d[1:0] : m_sen;
      default: m_lat = m_lat;
    endcase
    settle();
  endtask : wr
  task automatic rd(input logic [11:0] ad);
    settle();
    xfer(1'b0, ad, 32'h0, 4'h0);
    settle();
  endtask : rd
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : conclude
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    void'($urandom(32'h7C07));
    req = '0;
    nrst = 1'b0;
    ext = 8'h5A;
    m_lat = 8'h00;
    m_dir = 8'hFF;
    m_ans = 8'hFF;
    m_sen = 2'h0;
    repeat (16) @(posedge ref_clk);
    nrst <= 1'b1;
    rd(BGP_OFS_DIR);
    `CHK(rdat[7:0], 8'hFF)
    `CHK(rsp_abs.prdata, 32'h0)
    `CHK(pin_oe, 8'h00)
    `CHK(ana, 8'hFF)
    rd(BGP_OFS_DATA);
    `CHK(rdat, 32'h0)
    // Outputs driven while every pin is still analog.
    wr(BGP_OFS_DATA, 8'hA5, 4'h1);
    wr(BGP_OFS_DIR, 8'h00, 4'h1);
    `CHK(pin_o, 8'hA5)
    `CHK(pin_oe, 8'hFF)
    rd(BGP_OFS_DATA);
    `CHK(rdat, 32'h0)
    wr(BGP_OFS_ANALOG, 8'h00, 4'h1);
    // Random directions, analog pins, sense channels and latch writes.
    for (int k = 0; k < 30; k++) begin
      @(posedge ref_clk);
      ext <= 8'($urandom);
      wr(BGP_OFS_DIR, 8'($urandom), 4'h1);
      wr(BGP_OFS_ANALOG, (k % 4 == 3) ? 8'($urandom) : 8'h00, 4'h1);
      wr(BGP_OFS_SENSE, 8'(k % 4), 4'h1);
      a = (k % 3 == 0) ? BGP_OFS_DATA : (k % 3 == 1) ? BGP_OFS_SET
        : BGP_OFS_CLR;
      wr(a, 8'($urandom), 4'(k % 2));
      v = m_pins();
      `CHK(pin_o, m_lat)
      `CHK(pin_oe, m_oe())
      `CHK(ana, m_ans)
      `CHK({ch13, ch12, cs12}, {m_sen, m_sen[0] & v[4]})
      `CHK(cs13, m_sen[1] & v[5])
      rd(BGP_OFS_DATA);
      `CHK(rdat, {24'h0, v & ~m_ans})
      rd(BGP_OFS_SET);
      `CHK(rdat, {24'h0, m_lat})
      `CHK(rsp_abs.prdata, 32'h0)
    end
    // Unmapped word: error answer, zero data, latch untouched.
    wr(12'h018, 8'hFF, 4'hF);
    `CHK(rerr, 1'b1)
    rd(12'h020);
    `CHK({rerr, rdat}, {1'b1, 32'h0})
    `CHK(pin_o, m_lat)
    conclude();
  end
endmodule : bidir_io_port_eight_bit_bench
